// [cild_regs.vh]
// Purpose: constants for the compressed load/store and branch-exchange decoder
// Assumes: 16-bit instruction words, 32-bit registers and addresses
// Notes: opcode prefixes are matched on the top bits of the instruction
`ifndef CILD_REGS_VH
`define CILD_REGS_VH

// instruction class prefixes
`define CILD_F5_TOP 6'h11
`define CILD_F6_TOP 5'h09
`define CILD_F78_TOP 4'h5
`define CILD_F9_TOP 3'h3

// high-register operation codes
`define CILD_OP_ADD 2'h0
`define CILD_OP_CMP 2'h1
`define CILD_OP_MOV 2'h2
`define CILD_OP_BX 2'h3

// transfer sizes on the memory port
`define CILD_SZ_BYTE 2'h0
`define CILD_SZ_HALF 2'h1
`define CILD_SZ_WORD 2'h2

// program counter operand handling
`define CILD_PC_AHEAD 32'h0000_0004
`define CILD_PC_INDEX 4'hf

// flag vector bit positions
`define CILD_FLAG_N 3
`define CILD_FLAG_Z 2
`define CILD_FLAG_C 1
`define CILD_FLAG_V 0

// instruction state after reset: 0 = 32-bit state
`define CILD_STATE_RESET 1'b0

`endif

// [cild_decode.v]
// Purpose: decode and sequence compressed branch-exchange, high-register and load/store instructions
// Assumes: register file reads combinationally from the flopped select outputs;
//          memory read data arrives right-aligned in the low bits
// Notes: one instruction in flight; instr_valid_in is taken only while ready_out is high
//        a done from memory in the issue cycle itself is ignored, the request flops a cycle later
//        a branch through the pc from a non-word-aligned address is not trapped; software must avoid it
//        undefined encodings only pulse undefined_out; no register, flag or state changes
// Contract
// RQ1: branch_exchange jumps; target bit0 selects state
// RQ2: branch_exchange with dest_high_flag set is undefined
// RQ3: program_counter_reg operand reads address+4, bit0 clear
// RQ4: branch_exchange via pc when unaligned: unpredictable
// RQ5: pc load adds pc_offset_field times four
// RQ6: pc load base is address+4, bit1 clear
// RQ7: register offset address is base plus index
// RQ8: register-offset way/size pick word/byte load/store
// RQ9: store_half writes source bits 0-15
// RQ10: load_half zero-fills bits 16-31
// RQ11: load_signed_byte copies bit 7 upward
// RQ12: load_signed_half copies bit 15 upward
// RQ13: immediate transfer adds imm_offset_field to base
// RQ14: immediate word offset is field times four
// RQ15: cycle count same as 32-bit equivalent
// RQ16: high add and move keep flags
// RQ17: only high compare updates status_flags_reg
// RQ18: load_byte zero-fills, byte store writes bits 0-7
`include "cild_regs.vh"

module cild_decode (
  input wire clk_in,
  input wire reset_in,
  input wire instr_valid_in,
  input wire [15:0] instr_in,
  input wire [31:0] instr_addr_in,
  input wire [31:0] reg_a_val_in,
  input wire [31:0] reg_b_val_in,
  input wire [31:0] reg_d_val_in,
  input wire [31:0] mem_rdata_in,
  input wire mem_done_in,
  output reg ready_out,
  output reg [3:0] reg_a_sel_out,
  output reg [3:0] reg_b_sel_out,
  output reg [3:0] reg_d_sel_out,
  output reg mem_req_out,
  output reg mem_write_out,
  output reg [1:0] mem_size_out,
  output reg [31:0] mem_addr_out,
  output reg [31:0] mem_wdata_out,
  output reg wb_en_out,
  output reg [3:0] wb_reg_out,
  output reg [31:0] wb_data_out,
  output reg branch_out,
  output reg [31:0] branch_target_out,
  output reg state_compressed_out,
  output reg flags_we_out,
  output reg [3:0] flags_out,
  output reg undefined_out
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_OPER = 3'b010;
  localparam [2:0] ST_MEM = 3'b100;

  reg [2:0] state;
  reg [15:0] instr;
  reg [31:0] pc_ahead;
  reg load_signed;
  reg [1:0] load_size;

  // instruction fields
  wire is_f5 = (instr[15:10] == `CILD_F5_TOP);
  wire is_f6 = (instr[15:11] == `CILD_F6_TOP);
  wire is_f78 = (instr[15:12] == `CILD_F78_TOP);
  wire is_f8 = is_f78 & instr[9];
  wire is_f9 = (instr[15:13] == `CILD_F9_TOP);
  wire [1:0] hi_op = instr[9:8];
  wire dest_high_flag = instr[7];
  wire src_high_flag = instr[6];
  wire [7:0] pc_offset_field = instr[7:0];
  wire [4:0] imm_offset_field = instr[10:6];

  // program counter substitution for any operand that names it
  wire [31:0] pc_operand = {pc_ahead[31:1], 1'b0}; // [RQ3]
  wire [31:0] val_a = (reg_a_sel_out == `CILD_PC_INDEX) ? pc_operand : reg_a_val_in;
  wire [31:0] val_b = (reg_b_sel_out == `CILD_PC_INDEX) ? pc_operand : reg_b_val_in;
  wire [31:0] val_d = (reg_d_sel_out == `CILD_PC_INDEX) ? pc_operand : reg_d_val_in;

  // high-register arithmetic
  wire [31:0] hi_sum = val_d + val_a;
  wire [32:0] hi_diff = {1'b0, val_d} - {1'b0, val_a};
  wire hi_ovf = (val_d[31] ^ val_a[31]) & (val_d[31] ^ hi_diff[31]);
  wire hi_dest_pc = ({dest_high_flag, instr[2:0]} == `CILD_PC_INDEX);

  // add/move result; move passes the source through untouched
  reg [31:0] next_hi_result;
  always @*
  begin
    case (hi_op)
      `CILD_OP_ADD:
        next_hi_result = hi_sum;
      default:
        next_hi_result = val_a;
    endcase
  end

  // compare flags; carry is the inverse of the borrow out of the subtraction
  reg [3:0] next_flags;
  always @*
  begin
    next_flags = 4'h0;
    next_flags[`CILD_FLAG_N] = hi_diff[31];
    next_flags[`CILD_FLAG_Z] = (hi_diff[31:0] == 32'h0000_0000);
    next_flags[`CILD_FLAG_C] = ~hi_diff[32];
    next_flags[`CILD_FLAG_V] = hi_ovf;
  end

  // effective addresses
  wire [31:0] pc_base = {pc_ahead[31:2], 2'b00}; // [RQ6]
  wire [31:0] pc_addr = pc_base + {22'h00_0000, pc_offset_field, 2'b00}; // [RQ5]
  wire [31:0] reg_addr = val_a + val_b; // [RQ7]
  wire [31:0] imm_scaled = instr[12] ? {27'h000_0000, imm_offset_field}
                                     : {25'h000_0000, imm_offset_field, 2'b00}; // [RQ14]
  wire [31:0] imm_addr = val_a + imm_scaled; // [RQ13]

  // transfer decode; the sign/half form uses bit 10 for signed and bit 11 for halfword
  wire xfer_byte = is_f9 ? instr[12] : instr[10];
  wire [1:0] xfer_size = xfer_byte ? `CILD_SZ_BYTE : `CILD_SZ_WORD; // [RQ8]
  wire f8_store = ~instr[10] & ~instr[11];
  wire f8_byte = instr[10] & ~instr[11];
  wire [1:0] f8_size = f8_byte ? `CILD_SZ_BYTE : `CILD_SZ_HALF;

  // operand selects; the high-register form carries a fourth select bit per operand
  reg [3:0] next_sel_a;
  reg [3:0] next_sel_b;
  reg [3:0] next_sel_d;
  always @*
  begin
    if (instr_in[15:10] == `CILD_F5_TOP)
    begin
      next_sel_a = {instr_in[6], instr_in[5:3]};
      next_sel_b = 4'h0;
      next_sel_d = {instr_in[7], instr_in[2:0]};
    end
    else
    begin
      // low registers only; index_reg is limited to 0-7 [RQ7]
      next_sel_a = {1'b0, instr_in[5:3]};
      next_sel_b = {1'b0, instr_in[8:6]};
      next_sel_d = {1'b0, instr_in[2:0]};
    end
  end

  // load data extension
  reg [31:0] next_load_data;
  always @*
  begin
    next_load_data = mem_rdata_in;
    case (load_size)
      `CILD_SZ_BYTE:
      begin
        if (load_signed)
          next_load_data = {{24{mem_rdata_in[7]}}, mem_rdata_in[7:0]}; // [RQ11]
        else
          next_load_data = {24'h00_0000, mem_rdata_in[7:0]}; // [RQ18]
      end
      `CILD_SZ_HALF:
      begin
        if (load_signed)
          next_load_data = {{16{mem_rdata_in[15]}}, mem_rdata_in[15:0]}; // [RQ12]
        else
          next_load_data = {16'h0000, mem_rdata_in[15:0]}; // [RQ10]
      end
      default:
        next_load_data = mem_rdata_in;
    endcase
  end

  // store data narrowing; upper bits zero so the memory side never sees stale lanes
  function [31:0] narrow;
    input [1:0] size;
    input [31:0] data;
    begin
      case (size)
        `CILD_SZ_BYTE: narrow = {24'h00_0000, data[7:0]}; // [RQ18]
        `CILD_SZ_HALF: narrow = {16'h0000, data[15:0]}; // [RQ9]
        default: narrow = data;
      endcase
    end
  endfunction

  // the same state walk serves both instruction states, so timing matches [RQ15]
  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      state <= ST_IDLE;
      instr <= 16'h0000;
      pc_ahead <= 32'h0000_0000;
      load_signed <= 1'b0;
      load_size <= `CILD_SZ_WORD;
      ready_out <= 1'b1;
      reg_a_sel_out <= 4'h0;
      reg_b_sel_out <= 4'h0;
      reg_d_sel_out <= 4'h0;
      mem_req_out <= 1'b0;
      mem_write_out <= 1'b0;
      mem_size_out <= `CILD_SZ_WORD;
      mem_addr_out <= 32'h0000_0000;
      mem_wdata_out <= 32'h0000_0000;
      wb_en_out <= 1'b0;
      wb_reg_out <= 4'h0;
      wb_data_out <= 32'h0000_0000;
      branch_out <= 1'b0;
      branch_target_out <= 32'h0000_0000;
      state_compressed_out <= `CILD_STATE_RESET;
      flags_we_out <= 1'b0;
      flags_out <= 4'h0;
      undefined_out <= 1'b0;
    end
    else
    begin
      wb_en_out <= 1'b0;
      branch_out <= 1'b0;
      flags_we_out <= 1'b0;
      undefined_out <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (instr_valid_in)
          begin
            instr <= instr_in;
            pc_ahead <= instr_addr_in + `CILD_PC_AHEAD; // [RQ3]
            ready_out <= 1'b0;
            state <= ST_OPER;
            reg_a_sel_out <= next_sel_a;
            reg_b_sel_out <= next_sel_b;
            reg_d_sel_out <= next_sel_d;
          end
        end
        ST_OPER:
        begin
          state <= ST_IDLE;
          ready_out <= 1'b1;
          if (is_f5)
          begin
            wb_reg_out <= {dest_high_flag, instr[2:0]};
            case (hi_op)
              `CILD_OP_ADD, `CILD_OP_MOV:
              begin
                if (!dest_high_flag && !src_high_flag)
                  undefined_out <= 1'b1;
                else if (hi_dest_pc)
                begin
                  // writing the pc branches without a state change or flag update [RQ16]
                  branch_out <= 1'b1;
                  branch_target_out <= {next_hi_result[31:1], 1'b0};
                end
                else
                begin
                  wb_en_out <= 1'b1; // [RQ16]
                  wb_data_out <= next_hi_result;
                end
              end
              `CILD_OP_CMP:
              begin
                if (!dest_high_flag && !src_high_flag)
                  undefined_out <= 1'b1;
                else
                begin
                  flags_we_out <= 1'b1; // [RQ17]
                  flags_out <= next_flags;
                end
              end
              default:
              begin
                if (dest_high_flag)
                  undefined_out <= 1'b1; // [RQ2]
                else
                begin
                  // an unaligned pc target is passed through as is; outcome is left open [RQ4]
                  branch_out <= 1'b1;
                  branch_target_out <= {val_a[31:1], 1'b0}; // [RQ1]
                  state_compressed_out <= val_a[0]; // [RQ1]
                end
              end
            endcase
          end
          else if (is_f6 || is_f78 || is_f9)
          begin
            state <= ST_MEM;
            ready_out <= 1'b0;
            mem_req_out <= 1'b1;
            wb_reg_out <= is_f6 ? {1'b0, instr[10:8]} : {1'b0, instr[2:0]};
            if (is_f6)
            begin
              mem_write_out <= 1'b0;
              mem_size_out <= `CILD_SZ_WORD;
              mem_addr_out <= pc_addr; // [RQ5]
              load_size <= `CILD_SZ_WORD;
              load_signed <= 1'b0;
            end
            else if (is_f8)
            begin
              mem_write_out <= f8_store; // [RQ9]
              mem_size_out <= f8_size;
              mem_addr_out <= reg_addr; // [RQ7]
              mem_wdata_out <= narrow(`CILD_SZ_HALF, val_d); // [RQ9]
              load_size <= f8_size;
              load_signed <= instr[10]; // [RQ11] [RQ12]
            end
            else
            begin
              // way is bit 11, size is bit 10 (f7) or bit 12 (f9)
              mem_write_out <= ~instr[11]; // [RQ8]
              mem_size_out <= xfer_size; // [RQ8]
              mem_addr_out <= is_f9 ? imm_addr : reg_addr; // [RQ13]
              mem_wdata_out <= narrow(xfer_size, val_d); // [RQ18]
              load_size <= xfer_size;
              load_signed <= 1'b0; // [RQ18]
            end
          end
          else
            undefined_out <= 1'b1;
        end
        ST_MEM:
        begin
          if (mem_done_in)
          begin
            mem_req_out <= 1'b0;
            state <= ST_IDLE;
            ready_out <= 1'b1;
            if (!mem_write_out)
            begin
              wb_en_out <= 1'b1;
              wb_data_out <= next_load_data;
            end
          end
        end
        default:
        begin
          state <= ST_IDLE;
          ready_out <= 1'b1;
          mem_req_out <= 1'b0;
        end
      endcase
    end
  end

endmodule

// [cild_decode_properties.sv]
// Purpose: port timing checks for cild_decode
// Assumes: one clock, synchronous active-high reset
// Notes: bound into every decoder instance
module cild_decode_props (
  input wire clk_in,
  input wire reset_in,
  input wire instr_valid_in,
  input wire mem_done_in,
  input wire ready_out,
  input wire mem_req_out,
  input wire mem_write_out,
  input wire [1:0] mem_size_out,
  input wire [31:0] mem_addr_out,
  input wire [31:0] mem_wdata_out,
  input wire wb_en_out,
  input wire branch_out,
  input wire [31:0] branch_target_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  a_take_busy: assert property (ready_out && instr_valid_in |=> !ready_out)
    else $error("ready stayed high after take");
  a_busy_bound: assert property (!ready_out && !mem_req_out |=> ready_out || mem_req_out)
    else $error("decoder stalled");
  a_req_idle: assert property (mem_req_out |-> !ready_out)
    else $error("ready during memory request");
  a_req_drop: assert property (mem_req_out && mem_done_in |=> !mem_req_out && ready_out)
    else $error("request not closed after done");
  a_req_hold: assert property (mem_req_out && !mem_done_in |=>
    mem_req_out && $stable(mem_addr_out) && $stable(mem_write_out))
    else $error("request changed while pending");
  a_byte_wdata: assert property (mem_req_out && mem_write_out && mem_size_out == 2'h0
    |-> mem_wdata_out[31:8] == 24'h0)
    else $error("byte store upper bits set");
  a_half_wdata: assert property (mem_req_out && mem_write_out && mem_size_out == 2'h1
    |-> mem_wdata_out[31:16] == 16'h0)
    else $error("half store upper bits set");
  a_wb_pulse: assert property (wb_en_out |=> !wb_en_out)
    else $error("writeback longer than a cycle");
  a_branch_even: assert property (branch_out |-> !branch_target_out[0] && ready_out && !wb_en_out)
    else $error("branch target odd or busy");
endmodule

bind cild_decode cild_decode_props u_props (.clk_in(clk_in), .reset_in(reset_in),
  .instr_valid_in(instr_valid_in), .mem_done_in(mem_done_in), .ready_out(ready_out),
  .mem_req_out(mem_req_out), .mem_write_out(mem_write_out), .mem_size_out(mem_size_out),
  .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out), .wb_en_out(wb_en_out),
  .branch_out(branch_out), .branch_target_out(branch_target_out));

// [cild_mem_model.sv]
// Purpose: data memory partner with adjustable latency
// Assumes: one done pulse per request
// Notes: a released data bus shows the inverse so stale data never looks valid
module cild_mem_model (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic mem_req_in,
  input wire logic [3:0] lat_in,
  input wire logic [31:0] load_in,
  output logic mem_done_out,
  output logic [31:0] mem_rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt;
  assign mem_rdata_out = mem_done_out ? load_in : ~load_in;
  always @(posedge clk_in)
  begin
    if (reset_in || !mem_req_in || mem_done_out)
    begin
      wait_cnt <= 4'h0;
      mem_done_out <= 1'b0;
    end
    else if (wait_cnt == lat_in)
      mem_done_out <= 1'b1;
    else
      wait_cnt <= wait_cnt + 4'h1;
  end
endmodule

// [tb_top.sv]
// Purpose: self-checking bench for cild_decode
// Assumes: register file modelled as a static array
// Notes: results are gathered at falling edges until ready returns
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, reset_in, instr_valid_in;
  logic [15:0] instr_in;
  logic [31:0] instr_addr_in, ld, e, m_addr, m_wdata, s_data;
  logic [31:0] rf [16];
  logic [3:0] lat, s_reg;
  logic [1:0] m_size;
  logic m_wr, s_wb, s_br, s_fl, s_ud;
  wire mem_done_in, ready_out, mem_req_out, mem_write_out, wb_en_out, branch_out;
  wire state_compressed_out, flags_we_out, undefined_out;
  wire [3:0] reg_a_sel_out, reg_b_sel_out, reg_d_sel_out, wb_reg_out, flags_out;
  wire [1:0] mem_size_out;
  wire [31:0] mem_rdata_in, mem_addr_out, mem_wdata_out, wb_data_out, branch_target_out;
  int errors, n_tests, i, cyc;
  cild_decode dut (.clk_in(clk_in), .reset_in(reset_in), .instr_valid_in(instr_valid_in),
    .instr_in(instr_in), .instr_addr_in(instr_addr_in), .reg_a_val_in(rf[reg_a_sel_out]),
    .reg_b_val_in(rf[reg_b_sel_out]), .reg_d_val_in(rf[reg_d_sel_out]), .mem_rdata_in(mem_rdata_in),
    .mem_done_in(mem_done_in), .ready_out(ready_out), .reg_a_sel_out(reg_a_sel_out),
    .reg_b_sel_out(reg_b_sel_out), .reg_d_sel_out(reg_d_sel_out), .mem_req_out(mem_req_out),
    .mem_write_out(mem_write_out), .mem_size_out(mem_size_out), .mem_addr_out(mem_addr_out),
    .mem_wdata_out(mem_wdata_out), .wb_en_out(wb_en_out), .wb_reg_out(wb_reg_out),
    .wb_data_out(wb_data_out), .branch_out(branch_out), .branch_target_out(branch_target_out),
    .state_compressed_out(state_compressed_out), .flags_we_out(flags_we_out),
    .flags_out(flags_out), .undefined_out(undefined_out));
  cild_mem_model mem (.clk_in(clk_in), .reset_in(reset_in), .mem_req_in(mem_req_out),
    .lat_in(lat), .load_in(ld), .mem_done_out(mem_done_in), .mem_rdata_out(mem_rdata_in));
  task test_done();
    if (errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, exp);
    end
  endtask
  // offer one instruction and collect every answer until ready returns
  task run(input logic [15:0] ins, input logic [31:0] adr);
    int k;
    instr_in = ins;
    instr_addr_in = adr;
    instr_valid_in = 1'b1;
    {s_wb, s_br, s_fl, s_ud} = 4'h0;
    // poison captured values so a missing transfer cannot match a stale one
    {m_wr, m_size, m_addr, m_wdata, s_reg, s_data} = '1;
    @(negedge clk_in);
    instr_valid_in = 1'b0;
    k = 0;
    do
    begin
      @(negedge clk_in);
      k++;
      if (mem_req_out && mem_done_in)
        {m_wr, m_size, m_addr, m_wdata} = {mem_write_out, mem_size_out, mem_addr_out, mem_wdata_out};
      if (wb_en_out)
        {s_wb, s_reg, s_data} = {1'b1, wb_reg_out, wb_data_out};
      s_br |= branch_out;
      s_fl |= flags_we_out;
      s_ud |= undefined_out;
    end
    while (ready_out !== 1'b1 && k < 40);
    cyc = k;
    if (ready_out !== 1'b1)
    begin
      errors++;
      test_done();
    end
  endtask
  task t_branch();
    run(16'h4758, 32'h0);
    chk(branch_target_out, 32'h1000_0000);
    chk({s_br, state_compressed_out}, 2'h3);
    chk(cyc, 1);
    run(16'h4710, 32'h0);
    chk({s_br, state_compressed_out}, 2'h2);
    chk(branch_target_out, 32'h0000_0024);
    run(16'h4798, 32'h0);
    chk({s_ud, s_br, s_wb}, 3'h4);
  endtask
  task t_pc_load();
    lat = 4'h2;
    run(16'h4bff, 32'h0000_0106);
    chk(m_addr, 32'h0000_0504);
    chk({m_wr, m_size, s_reg}, {1'b0, 2'h2, 4'h3});
    chk(s_data, ld);
  endtask
  task t_reg_off();
    for (i = 0; i < 4; i++)
    begin
      lat = i[3:0];
      run(16'h5000 | 16'(i << 10) | 16'h008c, 32'h0);
      e = i[1] ? ld : rf[4];
      if (i[0])
        e = e & 32'h0000_00ff;
      chk(m_addr, 32'h0000_0124);
      chk(cyc, 3 + i);
      chk({m_wr, m_size, s_wb}, {~i[1], i[0] ? 2'h0 : 2'h2, i[1]});
      chk(i[1] ? s_data : m_wdata, e);
    end
  endtask
  task t_sign();
    logic [31:0] ex [4];
    logic [1:0] sz [4];
    ex = '{32'h0000_f00d, 32'hffff_ff80, 32'h0000_8080, 32'hffff_8080};
    sz = '{2'h1, 2'h0, 2'h1, 2'h1};
    for (i = 0; i < 4; i++)
    begin
      run(16'h5200 | 16'(i << 10) | 16'h008c, 32'h0);
      chk({m_addr, m_wr, m_size}, {32'h0000_0124, i == 0, sz[i]});
      chk(i != 0 ? s_data : m_wdata, ex[i]);
    end
  endtask
  task t_imm();
    for (i = 0; i < 4; i++)
    begin
      run(16'h6000 | 16'(i << 11) | 16'h07cc, 32'h0);
      chk(m_addr, i[1] ? 32'h0000_011f : 32'h0000_017c);
      chk({m_wr, m_size}, {~i[0], i[1] ? 2'h0 : 2'h2});
    end
  endtask
  task t_high();
    run(16'h4565, 32'h0);
    chk({s_fl, s_wb, flags_out}, 6'h26);
    run(16'h4649, 32'h0);
    chk({s_fl, s_wb, s_reg, s_data}, {2'h1, 4'h1, 32'h0000_abcd});
    run(16'h4449, 32'h0);
    chk({s_fl, s_data}, {1'b0, 32'h0000_accd});
    run(16'h4678, 32'h0000_0202);
    chk(s_data, 32'h0000_0206);
    run(16'h44af, 32'h0000_0200);
    chk({s_br, s_fl, s_wb, state_compressed_out}, 4'h8);
    chk(branch_target_out, 32'h0000_0208);
  endtask
  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  initial
  begin
    reset_in = 1'b1;
    instr_valid_in = 1'b0;
    instr_in = 16'h0;
    instr_addr_in = 32'h0;
    lat = 4'h0;
    ld = 32'h1234_8080;
    rf = '{default: 32'h0};
    rf[1] = 32'h0000_0100;
    rf[2] = 32'h0000_0024;
    rf[4] = 32'hcafe_f00d;
    rf[5] = 32'h0000_0005;
    rf[9] = 32'h0000_abcd;
    rf[11] = 32'h1000_0001;
    rf[12] = 32'h0000_0005;
    rf[15] = 32'hdead_0000;
    repeat (8) @(negedge clk_in);
    reset_in = 1'b0;
    t_branch();
    t_pc_load();
    t_reg_off();
    t_sign();
    t_imm();
    t_high();
    test_done();
  end
endmodule
